/* logic/radio_evt_pkg.sv */
// Constants and carrier types for the radio task and event register set
package radio_evt_pkg;

    localparam int ADDR_W = 12;

    // Register byte offsets
    localparam logic [11:0] OFF_TASK_HALT          = 12'h00C;
    localparam logic [11:0] OFF_TASK_TURN_OFF      = 12'h010;
    localparam logic [11:0] OFF_TASK_SAMPLE_GO     = 12'h014;
    localparam logic [11:0] OFF_TASK_SAMPLE_HALT   = 12'h018;
    localparam logic [11:0] OFF_TASK_BITCOUNT_GO   = 12'h01C;
    localparam logic [11:0] OFF_TASK_BITCOUNT_HALT = 12'h020;
    localparam logic [11:0] OFF_EVT_RAMPUP_DONE    = 12'h100;
    localparam logic [11:0] OFF_EVT_ADDR_DONE      = 12'h104;
    localparam logic [11:0] OFF_EVT_BODY_DONE      = 12'h108;
    localparam logic [11:0] OFF_EVT_FRAME_DONE     = 12'h10C;
    localparam logic [11:0] OFF_EVT_TURNED_OFF     = 12'h110;
    localparam logic [11:0] OFF_EVT_STATION_HIT    = 12'h114;
    localparam logic [11:0] OFF_EVT_STATION_NONE   = 12'h118;
    localparam logic [11:0] OFF_EVT_SAMPLE_DONE    = 12'h11C;
    localparam logic [11:0] OFF_EVT_BITCOUNT_HIT   = 12'h128;
    localparam logic [11:0] OFF_EVT_CHECK_GOOD     = 12'h130;
    localparam logic [11:0] OFF_EVT_CHECK_BAD      = 12'h134;
    localparam logic [11:0] OFF_EVT_SEND_UP        = 12'h154;
    localparam logic [11:0] OFF_EVT_RECV_UP        = 12'h158;
    localparam logic [11:0] OFF_EVT_AIR_LAST_BIT   = 12'h16C;
    localparam logic [11:0] OFF_EVENT_TASK_LINKS   = 12'h200;
    localparam logic [11:0] OFF_SAMPLE_VALUE       = 12'h548;
    localparam logic [11:0] OFF_BITCOUNT_COMPARE   = 12'h560;

    // Event slot positions in the pending vector
    localparam int EV_RAMPUP  = 0;
    localparam int EV_ADDR    = 1;
    localparam int EV_BODY    = 2;
    localparam int EV_FRAME   = 3;
    localparam int EV_OFF     = 4;
    localparam int EV_HIT     = 5;
    localparam int EV_NONE    = 6;
    localparam int EV_SAMPLE  = 7;
    localparam int EV_BCHIT   = 8;
    localparam int EV_GOOD    = 9;
    localparam int EV_BAD     = 10;
    localparam int EV_SEND    = 11;
    localparam int EV_RECV    = 12;
    localparam int EV_AIR     = 13;
    localparam int EV_NUM     = 14;

    // Link bit positions in event_task_links
    localparam int LK_READY_START     = 0;
    localparam int LK_END_OFF         = 1;
    localparam int LK_OFF_SEND_EN     = 2;
    localparam int LK_OFF_RECV_EN     = 3;
    localparam int LK_ADDR_SAMPLE_GO  = 4;
    localparam int LK_END_START       = 5;
    localparam int LK_ADDR_BC_GO      = 6;
    localparam int LK_OFF_SAMPLE_HALT = 8;
    localparam int LK_SEND_UP_START   = 19;
    localparam int LK_RECV_UP_START   = 20;
    localparam int LK_AIR_OFF         = 21;
    localparam int LK_AIR_START       = 22;
    localparam logic [31:0] LINKS_MASK  = 32'h0078_017F;

    // Reset values
    localparam logic [31:0] LINKS_RESET = 32'h0000_0000;
    localparam logic [31:0] BCC_RESET   = 32'h0000_0000;
    localparam logic [6:0]  SAMPLE_RESET = 7'h00;

    // Sampling settle time
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int SAMPLE_SETTLE_NS = 250;
    localparam int SAMPLE_CYCLES   =
        (SAMPLE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] SAMPLE_LOAD = 8'(SAMPLE_CYCLES - 1);

    typedef enum logic [2:0] {
        SMP_IDLE    = 3'b001,
        SMP_SETTLE  = 3'b010,
        SMP_CAPTURE = 3'b100
    } smp_state_type;

    // One-cycle pulses from the radio core
    typedef struct packed {
        logic rampup_done;
        logic addr_done;
        logic body_done;
        logic frame_done;
        logic turned_off;
        logic station_hit;
        logic station_none;
        logic check_good;
        logic check_bad;
        logic send_path_up;
        logic recv_path_up;
        logic air_last_bit;
    } core_evt_type;

    // One-cycle task requests to the radio core
    typedef struct packed {
        logic turn_off;
        logic halt;
        logic start;
        logic send_en;
        logic recv_en;
    } core_task_type;

endpackage

/* logic/radio_task_event_registers.sv */
// APB task and event register set of the packet radio
// What this block does
// - Sample-go task takes exactly one strength sample
// - Sample-halt task ends a measurement still in its settle phase
// - Bitcount-go task starts the payload bit counter, only after an address event
// - Bitcount-halt task stops the bit counter
// - Set ramp-up-done event when radio ramped up
// - Set send-path-up event after transmit ramp-up
// - Set receive-path-up event after receive ramp-up
// - Set address event after address field done
// - Set body event after payload done
// - Set frame event after whole packet done
// - Set turned-off event when radio is disabled
// - Set station-hit event on device address match
// - Set station-none event when no address matched
// - Set sample-done event when new sample readable
// - Set bitcount-hit event when counter reaches compare
// - At most one of check-good or check-bad per cycle, good wins
// - Set air-last-bit event when last bit on air
// - Event-to-task links register, all off after reset
`timescale 1ns/1ps
module radio_task_event_registers (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [radio_evt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire radio_evt_pkg::core_evt_type core_evt,
    input  wire logic                        bit_tick,
    input  wire logic [6:0]                  strength_level,
    output radio_evt_pkg::core_task_type     core_task,
    output logic                             sample_busy
);
    import radio_evt_pkg::*;

    // Event slot for an address: bit 4 marks a hit
    function automatic logic [4:0] evt_slot(input logic [11:0] a);
        logic [4:0] s;
        s = 5'h00;
        unique case (a)
            OFF_EVT_RAMPUP_DONE:  s = {1'b1, 4'(EV_RAMPUP)};
            OFF_EVT_ADDR_DONE:    s = {1'b1, 4'(EV_ADDR)};
            OFF_EVT_BODY_DONE:    s = {1'b1, 4'(EV_BODY)};
            OFF_EVT_FRAME_DONE:   s = {1'b1, 4'(EV_FRAME)};
            OFF_EVT_TURNED_OFF:   s = {1'b1, 4'(EV_OFF)};
            OFF_EVT_STATION_HIT:  s = {1'b1, 4'(EV_HIT)};
            OFF_EVT_STATION_NONE: s = {1'b1, 4'(EV_NONE)};
            OFF_EVT_SAMPLE_DONE:  s = {1'b1, 4'(EV_SAMPLE)};
            OFF_EVT_BITCOUNT_HIT: s = {1'b1, 4'(EV_BCHIT)};
            OFF_EVT_CHECK_GOOD:   s = {1'b1, 4'(EV_GOOD)};
            OFF_EVT_CHECK_BAD:    s = {1'b1, 4'(EV_BAD)};
            OFF_EVT_SEND_UP:      s = {1'b1, 4'(EV_SEND)};
            OFF_EVT_RECV_UP:      s = {1'b1, 4'(EV_RECV)};
            OFF_EVT_AIR_LAST_BIT: s = {1'b1, 4'(EV_AIR)};
            default:              s = 5'h00;
        endcase
        return s;
    endfunction

    function automatic logic is_task(input logic [11:0] a);
        return (a == OFF_TASK_HALT) || (a == OFF_TASK_TURN_OFF) ||
               (a == OFF_TASK_SAMPLE_GO) || (a == OFF_TASK_SAMPLE_HALT) ||
               (a == OFF_TASK_BITCOUNT_GO) ||
               (a == OFF_TASK_BITCOUNT_HALT);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        logic [4:0] s;
        s = evt_slot(a);
        return s[4] || is_task(a) ||
               (a == OFF_EVENT_TASK_LINKS) || (a == OFF_SAMPLE_VALUE) ||
               (a == OFF_BITCOUNT_COMPARE);
    endfunction

    logic [EV_NUM-1:0] evt_ff;
    logic [EV_NUM-1:0] nxt_evt_ff;
    logic [EV_NUM-1:0] evt_set;
    logic [31:0]       links_ff;
    logic [31:0]       nxt_links_ff;
    logic [31:0]       bcc_ff;
    logic [31:0]       nxt_bcc_ff;
    logic [31:0]       prdata_ff;
    logic [31:0]       nxt_prdata_ff;
    core_task_type     task_ff;
    core_task_type     nxt_task_ff;
    smp_state_type     smp_ff;
    smp_state_type     nxt_smp_ff;
    logic [7:0]        smp_cnt_ff;
    logic [7:0]        nxt_smp_cnt_ff;
    logic [6:0]        sample_ff;
    logic [6:0]        nxt_sample_ff;
    logic              addr_seen_ff;
    logic              nxt_addr_seen_ff;
    logic              bc_run_ff;
    logic              nxt_bc_run_ff;
    logic [31:0]       bc_cnt_ff;
    logic [31:0]       nxt_bc_cnt_ff;

    logic        wr;
    logic [4:0]  wslot;
    logic        tk_halt;
    logic        tk_off;
    logic        tk_smp_go;
    logic        tk_smp_halt;
    logic        tk_bc_go;
    logic        tk_bc_halt;
    logic        off_req;
    logic        smp_go;
    logic        smp_halt;
    logic        bc_go;
    logic        bc_stop;
    logic        smp_done;
    logic        bc_hit;
    logic [31:0] bc_inc;

    // Zero wait states; read data captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);
    assign prdata  = prdata_ff;
    assign core_task   = task_ff;
    assign sample_busy = (smp_ff != SMP_IDLE);

    assign wr    = psel & penable & pwrite & is_mapped(paddr);
    assign wslot = evt_slot(paddr);

    assign tk_halt     = wr & (paddr == OFF_TASK_HALT) & pwdata[0];
    assign tk_off      = wr & (paddr == OFF_TASK_TURN_OFF) & pwdata[0];
    assign tk_smp_go   = wr & (paddr == OFF_TASK_SAMPLE_GO) & pwdata[0];
    assign tk_smp_halt = wr & (paddr == OFF_TASK_SAMPLE_HALT) & pwdata[0];
    assign tk_bc_go    = wr & (paddr == OFF_TASK_BITCOUNT_GO) & pwdata[0];
    assign tk_bc_halt  = wr & (paddr == OFF_TASK_BITCOUNT_HALT) & pwdata[0];

    // links turn local events into local tasks
    assign off_req = tk_off |
        (links_ff[LK_END_OFF] & core_evt.frame_done) |
        (links_ff[LK_AIR_OFF] & core_evt.air_last_bit);
    assign smp_go = tk_smp_go |
        (links_ff[LK_ADDR_SAMPLE_GO] & core_evt.addr_done);
    // halt also on turn-off, since nothing may keep running
    assign smp_halt = tk_smp_halt | off_req |
        (links_ff[LK_OFF_SAMPLE_HALT] & core_evt.turned_off);
    assign bc_go = tk_bc_go |
        (links_ff[LK_ADDR_BC_GO] & core_evt.addr_done);
    assign bc_stop = tk_bc_halt | tk_halt | off_req | core_evt.frame_done;

    // Core-facing tasks, one-cycle pulses from flops
    always_comb begin
        nxt_task_ff.turn_off = off_req;
        nxt_task_ff.halt     = tk_halt;
        nxt_task_ff.start    =
            (links_ff[LK_READY_START] & core_evt.rampup_done) |
            (links_ff[LK_END_START] & core_evt.frame_done) |
            (links_ff[LK_SEND_UP_START] & core_evt.send_path_up) |
            (links_ff[LK_RECV_UP_START] & core_evt.recv_path_up) |
            (links_ff[LK_AIR_START] & core_evt.air_last_bit);
        nxt_task_ff.send_en  =
            links_ff[LK_OFF_SEND_EN] & core_evt.turned_off;
        nxt_task_ff.recv_en  =
            links_ff[LK_OFF_RECV_EN] & core_evt.turned_off;
    end

    // Strength sampling: settle, then capture one value
    always_comb begin
        nxt_smp_ff     = smp_ff;
        nxt_smp_cnt_ff = smp_cnt_ff;
        nxt_sample_ff  = sample_ff;
        smp_done       = 1'b0;
        unique case (smp_ff)
            SMP_IDLE: begin
                if (smp_go && !smp_halt) begin
                    nxt_smp_ff     = SMP_SETTLE;
                    nxt_smp_cnt_ff = SAMPLE_LOAD;
                end
            end
            SMP_SETTLE: begin
                if (smp_halt) begin
                    nxt_smp_ff = SMP_IDLE;
                end else if (smp_cnt_ff == 8'h00) begin
                    nxt_smp_ff = SMP_CAPTURE;
                end else begin
                    nxt_smp_cnt_ff = smp_cnt_ff - 8'h01;
                end
            end
            SMP_CAPTURE: begin
                nxt_sample_ff = strength_level;
                smp_done      = 1'b1;
                nxt_smp_ff    = SMP_IDLE;
            end
            default: begin
                nxt_smp_ff = SMP_IDLE;
            end
        endcase
    end

    // Bit counter; start is only honoured after an address
    assign bc_inc = bc_cnt_ff + 32'h0000_0001;
    // match on the tick that reaches the compare value
    assign bc_hit = bc_run_ff & bit_tick & (bc_inc == bcc_ff) & ~bc_stop;

    always_comb begin
        nxt_addr_seen_ff = addr_seen_ff;
        nxt_bc_run_ff    = bc_run_ff;
        nxt_bc_cnt_ff    = bc_cnt_ff;
        if (core_evt.addr_done) begin
            nxt_addr_seen_ff = 1'b1;
        end
        if (bc_stop) begin
            nxt_bc_run_ff    = 1'b0;
            nxt_bc_cnt_ff    = 32'h0000_0000;
            nxt_addr_seen_ff = 1'b0;
        end else if (bc_go && (addr_seen_ff || core_evt.addr_done)) begin
            nxt_bc_run_ff = 1'b1;
            nxt_bc_cnt_ff = 32'h0000_0000;
        end else if (bc_run_ff && bit_tick) begin
            nxt_bc_cnt_ff = bc_inc;
        end
    end

    // Event sources
    always_comb begin
        evt_set            = '0;
        evt_set[EV_RAMPUP] = core_evt.rampup_done;
        evt_set[EV_ADDR]   = core_evt.addr_done;
        evt_set[EV_BODY]   = core_evt.body_done;
        evt_set[EV_FRAME]  = core_evt.frame_done;
        evt_set[EV_OFF]    = core_evt.turned_off;
        evt_set[EV_HIT]    = core_evt.station_hit;
        evt_set[EV_NONE]   = core_evt.station_none & ~core_evt.station_hit;
        evt_set[EV_SAMPLE] = smp_done;
        evt_set[EV_BCHIT]  = bc_hit;
        // good wins if the core ever claims both
        evt_set[EV_GOOD]   = core_evt.check_good;
        evt_set[EV_BAD]    = core_evt.check_bad & ~core_evt.check_good;
        evt_set[EV_SEND]   = core_evt.send_path_up;
        evt_set[EV_RECV]   = core_evt.recv_path_up;
        evt_set[EV_AIR]    = core_evt.air_last_bit;
    end

    // Register writes and read capture
    always_comb begin
        nxt_evt_ff    = evt_ff | evt_set;
        nxt_links_ff  = links_ff;
        nxt_bcc_ff    = bcc_ff;
        nxt_prdata_ff = prdata_ff;
        // written value stored, a new event beats a clear
        if (wr && wslot[4]) begin
            nxt_evt_ff[wslot[3:0]] = pwdata[0] | evt_set[wslot[3:0]];
        end
        if (wr && paddr == OFF_EVENT_TASK_LINKS) begin
            nxt_links_ff = pwdata & LINKS_MASK;
        end
        if (wr && paddr == OFF_BITCOUNT_COMPARE) begin
            nxt_bcc_ff = pwdata;
        end
        if (psel && !penable && !pwrite) begin
            nxt_prdata_ff = 32'h0000_0000;
            if (wslot[4]) begin
                nxt_prdata_ff[0] = evt_ff[wslot[3:0]];
            end else if (paddr == OFF_EVENT_TASK_LINKS) begin
                nxt_prdata_ff = links_ff;
            end else if (paddr == OFF_BITCOUNT_COMPARE) begin
                nxt_prdata_ff = bcc_ff;
            end else if (paddr == OFF_SAMPLE_VALUE) begin
                nxt_prdata_ff[6:0] = sample_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_ff       <= '0;
            links_ff     <= LINKS_RESET;
            bcc_ff       <= BCC_RESET;
            prdata_ff    <= 32'h0000_0000;
            task_ff      <= '0;
            smp_ff       <= SMP_IDLE;
            smp_cnt_ff   <= 8'h00;
            sample_ff    <= SAMPLE_RESET;
            addr_seen_ff <= 1'b0;
            bc_run_ff    <= 1'b0;
            bc_cnt_ff    <= 32'h0000_0000;
        end else begin
            evt_ff       <= nxt_evt_ff;
            links_ff     <= nxt_links_ff;
            bcc_ff       <= nxt_bcc_ff;
            prdata_ff    <= nxt_prdata_ff;
            task_ff      <= nxt_task_ff;
            smp_ff       <= nxt_smp_ff;
            smp_cnt_ff   <= nxt_smp_cnt_ff;
            sample_ff    <= nxt_sample_ff;
            addr_seen_ff <= nxt_addr_seen_ff;
            bc_run_ff    <= nxt_bc_run_ff;
            bc_cnt_ff    <= nxt_bc_cnt_ff;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SAMPLE_ONCE: assert property (
        smp_go && !smp_halt && smp_ff == SMP_IDLE |=>
        smp_ff == SMP_SETTLE && !evt_set[EV_SAMPLE] ##1
        (!evt_set[EV_SAMPLE])[*8]
    ) else $error("sample event came too early");

    AST_SAMPLE_HALT: assert property (
        smp_halt && smp_ff == SMP_SETTLE |=>
        smp_ff == SMP_IDLE ##1 !evt_set[EV_SAMPLE]
    ) else $error("halted sampling still reported");

    AST_BC_START: assert property (
        bc_go && !bc_stop && (addr_seen_ff || core_evt.addr_done)
        |=> bc_run_ff && bc_cnt_ff == 32'h0000_0000
    ) else $error("bit counter did not start");

    AST_BC_HALT: assert property (
        tk_bc_halt |=> !bc_run_ff && !evt_set[EV_BCHIT]
    ) else $error("bit counter kept running");

    AST_BC_MATCH: assert property (
        bc_run_ff && bit_tick && !bc_stop && bc_inc == bcc_ff
        |=> evt_ff[EV_BCHIT]
    ) else $error("bit count match not flagged");

    AST_EVT_SET_WINS: assert property (
        core_evt.frame_done |=> evt_ff[EV_FRAME]
    ) else $error("frame event lost");

    AST_EVT_CLEAR: assert property (
        wr && paddr == OFF_EVT_ADDR_DONE && !pwdata[0] &&
        !core_evt.addr_done |=> !evt_ff[EV_ADDR]
    ) else $error("event clear ignored");

    AST_CHECK_ONE: assert property (
        !(evt_set[EV_GOOD] && evt_set[EV_BAD])
    ) else $error("both check events set together");

    AST_TURN_OFF: assert property (
        tk_off |=> core_task.turn_off && !sample_busy && !bc_run_ff
    ) else $error("turn-off did not stop activity");

    AST_ZERO_NO_TASK: assert property (
        wr && paddr == OFF_TASK_TURN_OFF && !pwdata[0]
        && !off_req |=> !core_task.turn_off
    ) else $error("zero write triggered a task");

    AST_LINK_START: assert property (
        links_ff[LK_READY_START] && core_evt.rampup_done
        |=> core_task.start
    ) else $error("ready link did not start");

    COV_SAMPLE: cover property (
        smp_go ##[1:40] evt_set[EV_SAMPLE]);
    COV_BC_HIT: cover property (bc_hit);
    COV_CLEAR_RACE: cover property (
        wr && wslot[4] && !pwdata[0] && evt_set[wslot[3:0]]);
    COV_OFF_LINK: cover property (
        links_ff[LK_END_OFF] && core_evt.frame_done);

endmodule

/* sim/radio_task_event_registers_test.sv */
// Self-checking APB bench for the radio task and event registers
`timescale 1ns/1ps
module radio_task_event_registers_test;
    import radio_evt_pkg::*;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    core_evt_type  core_evt;
    logic          bit_tick;
    logic [6:0]    strength_level;
    core_task_type core_task;
    logic          sample_busy;
    logic [31:0]   rd;
    logic          err;
    int            bad_count;
    int            num_checks;
    int            base;
    int            tcnt [5] = '{default: 0};
    // Same order as the core_evt fields, msb first
    logic [11:0]   evt_off [12] = '{OFF_EVT_RAMPUP_DONE, OFF_EVT_ADDR_DONE,
        OFF_EVT_BODY_DONE, OFF_EVT_FRAME_DONE, OFF_EVT_TURNED_OFF,
        OFF_EVT_STATION_HIT, OFF_EVT_STATION_NONE, OFF_EVT_CHECK_GOOD,
        OFF_EVT_CHECK_BAD, OFF_EVT_SEND_UP, OFF_EVT_RECV_UP,
        OFF_EVT_AIR_LAST_BIT};

    radio_task_event_registers DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_evt(core_evt),
        .bit_tick(bit_tick), .strength_level(strength_level),
        .core_task(core_task), .sample_busy(sample_busy)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Pulse tally, read before the edge's updates land
    always @(posedge pclk) begin
        for (int i = 0; i < 5; i++) begin
            if (core_task[i] === 1'b1) begin
                tcnt[i] <= tcnt[i] + 1;
            end
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic fail_out();
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            bad_count++;
            $display("[FAIL] %0t pulses %0d want %0d", $time, got, exp);
        end
    endtask

    // Held from setup until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_out();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input core_evt_type v);
        @(posedge pclk);
        core_evt <= v;
        @(posedge pclk);
        core_evt <= '0;
    endtask

    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge pclk);
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (sample_busy !== 1'b0) begin
            @(posedge pclk);
            n++;
            if (n > 100) begin
                fail_out();
            end
        end
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        core_evt = '0;
        bit_tick = 1'b0;
        strength_level = 7'h00;
        bad_count = 0;
        num_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_EVENT_TASK_LINKS, '0);
        check_reg(rd, LINKS_RESET);
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, evt_off[i], '0);
            check_reg(rd, 32'h0);
            pulse(core_evt_type'(12'h800 >> i));
            apb(1'b0, evt_off[i], '0);
            check_reg(rd, 32'h1);
            apb(1'b1, evt_off[i], '0);
            apb(1'b0, evt_off[i], '0);
            check_reg(rd, 32'h0);
        end
        $display("test events done");
        base = tcnt[4];
        apb(1'b1, OFF_TASK_TURN_OFF, 32'h0);
        repeat (3) @(posedge pclk);
        check_count(tcnt[4], base);
        apb(1'b1, OFF_TASK_TURN_OFF, 32'h1);
        repeat (3) @(posedge pclk);
        check_count(tcnt[4], base + 1);
        apb(1'b1, OFF_TASK_HALT, 32'h1);
        repeat (3) @(posedge pclk);
        check_count(tcnt[3], 1);
        apb(1'b0, OFF_TASK_SAMPLE_GO, '0);
        check_reg(rd, 32'h0);
        $display("test tasks done");
        strength_level <= 7'h2A;
        apb(1'b1, OFF_TASK_SAMPLE_GO, 32'h1);
        @(posedge pclk);
        check_reg({31'h0, sample_busy}, 32'h1);
        wait_idle();
        strength_level <= 7'h15;
        apb(1'b0, OFF_EVT_SAMPLE_DONE, '0);
        check_reg(rd, 32'h1);
        repeat (40) @(posedge pclk);
        // One capture only, later level changes must not show
        apb(1'b0, OFF_SAMPLE_VALUE, '0);
        check_reg(rd, 32'h2A);
        apb(1'b1, OFF_EVT_SAMPLE_DONE, '0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFF_TASK_SAMPLE_GO, 32'h1);
            apb(1'b1, k ? OFF_TASK_TURN_OFF : OFF_TASK_SAMPLE_HALT, 32'h1);
            @(posedge pclk);
            check_reg({31'h0, sample_busy}, 32'h0);
            repeat (40) @(posedge pclk);
            apb(1'b0, OFF_EVT_SAMPLE_DONE, '0);
            check_reg(rd, 32'h0);
        end
        $display("test sampling done");
        apb(1'b1, OFF_BITCOUNT_COMPARE, 32'h3);
        pulse(core_evt_type'(12'h400));
        apb(1'b1, OFF_TASK_BITCOUNT_GO, 32'h1);
        ticks(2);
        apb(1'b0, OFF_EVT_BITCOUNT_HIT, '0);
        check_reg(rd, 32'h0);
        ticks(1);
        apb(1'b0, OFF_EVT_BITCOUNT_HIT, '0);
        check_reg(rd, 32'h1);
        apb(1'b1, OFF_EVT_BITCOUNT_HIT, '0);
        apb(1'b1, OFF_TASK_BITCOUNT_HALT, 32'h1);
        // A running counter would hit the new compare within these ticks
        apb(1'b1, OFF_BITCOUNT_COMPARE, 32'h5);
        ticks(4);
        apb(1'b0, OFF_EVT_BITCOUNT_HIT, '0);
        check_reg(rd, 32'h0);
        $display("test bit counter done");
        apb(1'b0, 12'h300, '0);
        check_reg({31'h0, err}, 32'h1);
        check_reg(rd, 32'h0);
        apb(1'b1, OFF_EVENT_TASK_LINKS, 32'hFFFFFFFF);
        apb(1'b0, OFF_EVENT_TASK_LINKS, '0);
        check_reg(rd, LINKS_MASK);
        base = tcnt[2];
        pulse(core_evt_type'(12'h800));
        repeat (3) @(posedge pclk);
        check_count(tcnt[2], base + 1);
        pulse(core_evt_type'(12'h080));
        repeat (3) @(posedge pclk);
        check_count(tcnt[1], 1);
        check_count(tcnt[0], 1);
        apb(1'b1, OFF_EVENT_TASK_LINKS, '0);
        $display("test links done");
        print_verdict();
    end
endmodule
